// ===== core/xaddr_gen.sv
// Dual data pointer and external data move address generator.
// Assumes an APB master for software and a CPU sequencer that pulses
// pointer steps, pointer uses and move requests one cycle each.
// Summary of operation
// RQ1 - Select bit picks primary or secondary pointer.
// RQ2 - Direction field sets up or down per pointer.
// RQ3 - Toggle enable flips select on pointer use.
// RQ4 - Select bit reads back current selection.
// RQ5 - Each pointer has readable writable low, high.
// RQ6 - Pointer move: top byte plus selected pointer.
// RQ7 - Indirect move upper byte from dedicated register.
// RQ8 - Indirect middle byte from port2 or alternate.
// RQ9 - Relocation register sets base in 4KB steps.
// RQ10 - Software unlocks before writing relocation register.
// RQ11 - External data address is 24 bits wide.
// RQ12 - High source select is addressing control bit 3.
// RQ13 - Steps wrap in 16 bits; toggle follows step.
module xaddr_gen (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ptr_step,
  input wire logic ptr_use,
  input wire logic move_ptr,
  input wire logic move_ind,
  input wire logic [7:0] work_reg,
  output logic [xaddr_pkg::XA_W-1:0] xaddr,
  output logic xaddr_valid,
  output logic [xaddr_pkg::XA_W-1:0] external_data_ram_base
);
  import xaddr_pkg::*;

  // Maps a register index to a memory slot; returns 4'hF when the
  // index names no register, which the bus answers with an error.
  // Decoding sits in a function so that the write and the read paths
  // always share one table.
  function automatic logic [3:0] slot_of(input logic [11:0] a);
    unique case (a)
      IDX_P0_LOW: slot_of = S_P0L;
      IDX_P0_HIGH: slot_of = S_P0H;
      IDX_P1_LOW: slot_of = S_P1L;
      IDX_P1_HIGH: slot_of = S_P1H;
      IDX_SEL_CTRL: slot_of = S_SEL;
      IDX_ADDRESSING_CONTROL: slot_of = S_ADDRESSING_CONTROL;
      IDX_P0_TOP: slot_of = S_P0X;
      IDX_P1_TOP: slot_of = S_P1X;
      IDX_PORT2: slot_of = S_P2;
      IDX_ALT_HIGH: slot_of = S_ALT;
      IDX_RELOC: slot_of = S_RELOC;
      IDX_UNLOCK: slot_of = S_UNL;
      IDX_IND_UPPER: slot_of = S_MXU;
      default: slot_of = 4'hF;
    endcase
  endfunction

  // Flat view of every register slot.
  logic [8*NREG-1:0] q;
  // Registered read data from the memory.
  logic [7:0] mem_rd;
  // Unlock state and remaining open window.
  unlock_t ul_r, ul_nxt;
  logic [2:0] ul_cnt_r, ul_cnt_nxt;
  // APB access phase tracking: second cycle of a read waits for data.
  // Reads need it because the memory read data is itself registered.
  logic rd_wait_r;

  // Named views of the slots.
  wire [7:0] p0l = q[8*S_P0L +: 8];
  wire [7:0] p0h = q[8*S_P0H +: 8];
  wire [7:0] p1l = q[8*S_P1L +: 8];
  wire [7:0] p1h = q[8*S_P1H +: 8];
  wire [7:0] selc = q[8*S_SEL +: 8];
  wire [7:0] addressing_control = q[8*S_ADDRESSING_CONTROL +: 8];
  wire [7:0] p0x = q[8*S_P0X +: 8];
  wire [7:0] p1x = q[8*S_P1X +: 8];
  wire [7:0] port2_latch = q[8*S_P2 +: 8];
  wire [7:0] alt_high = q[8*S_ALT +: 8];
  wire [7:0] reloc = q[8*S_RELOC +: 8];
  wire [7:0] mxu = q[8*S_MXU +: 8];

  // Decoded bus access. Each register takes one aligned word, so the
  // byte address is four times the register index.
  wire addr_aligned = (paddr[1:0] == 2'b00);
  wire [11:0] bus_index = paddr >> 2;
  // A misaligned address is treated like an unmapped one.
  wire [3:0] bus_slot = addr_aligned ? slot_of(bus_index) : 4'hF;
  wire bus_mapped = (bus_slot != 4'hF);
  wire bus_acc = psel && penable;
  // A transfer completes at the edge where the master sees pready high.
  // Writes act only there, so a long access phase can neither write
  // twice nor advance the unlock sequence twice.
  wire bus_done = bus_acc && pready;
  wire bus_wr = bus_done && pwrite && bus_mapped;
  // Relocation writes outside the unlock window are dropped with a
  // normal answer, so software has to read back to see the effect.
  wire reloc_locked = (bus_slot == S_RELOC) && (ul_r != UL_OPEN);
  wire bus_wr_ok = bus_wr && !reloc_locked; // RQ10

  // Selection and step direction for the active pointer.
  wire sel = selc[SEL_BIT]; // RQ1 RQ4
  wire auto_toggle_enable = selc[TSL_BIT];
  wire [1:0] dir = selc[DIR_HI:DIR_LO];
  // Primary counts down on field x1, secondary counts down on 1x.
  wire down = sel ? dir[1] : dir[0]; // RQ2
  wire [15:0] act_ptr = sel ? {p1h, p1l} : {p0h, p0l};
  // 16-bit wrap; the top byte is never touched by a step.
  wire [15:0] stepped = down ? act_ptr - 16'h0001 : act_ptr + 16'h0001; // RQ13
  // Toggle after the instruction that used the pointer.
  wire do_toggle = auto_toggle_enable && (ptr_use || ptr_step); // RQ3
  wire [7:0] sel_upd = {selc[7:1], sel ^ do_toggle}; // RQ3

  // Hardware write port: the bus has priority, then pointer step, then
  // a toggle. Only one byte moves per cycle, so a step writes the low
  // byte and a following cycle carries the high byte.
  logic hw_pend_r;
  logic [7:0] hw_hi_r;
  logic hw_sel_r;
  logic hw_tog_r;
  logic wr_en;
  logic [3:0] wr_slot;
  logic [7:0] wr_data;
  logic [3:0] rd_slot;

  // Picks the single write into the register memory for this cycle.
  // One write port keeps the memory small; the price is that a pointer
  // step spreads over two cycles, or three when the toggle is enabled.
  always_comb begin
    wr_en = 1'b0;
    wr_slot = 4'h0;
    wr_data = RST_VAL;
    if (bus_wr_ok) begin
      // Software writes always win the port.
      wr_en = 1'b1;
      wr_slot = bus_slot;
      if (bus_slot == S_SEL) begin
        // Only the select, toggle and direction bits are kept.
        wr_data = pwdata[7:0] & SEL_MASK;
      end else if (bus_slot == S_ADDRESSING_CONTROL) begin
        // Only the high byte source bit is kept.
        wr_data = pwdata[7:0] & ADDRESSING_CONTROL_MASK; // RQ12
      end else begin
        wr_data = pwdata[7:0]; // RQ5
      end
    end else if (hw_pend_r) begin
      // Second cycle of a step: the high byte of the stepped pointer.
      wr_en = 1'b1;
      wr_slot = hw_sel_r ? S_P1H : S_P0H;
      wr_data = hw_hi_r;
    end else if (hw_tog_r) begin
      // Third cycle of a step: the toggle, once the count is complete.
      wr_en = 1'b1;
      wr_slot = S_SEL;
      wr_data = {selc[7:1], ~sel}; // RQ13
    end else if (ptr_step) begin
      // First cycle of a step: the low byte.
      wr_en = 1'b1;
      wr_slot = sel ? S_P1L : S_P0L;
      wr_data = stepped[7:0]; // RQ2
    end else if (do_toggle) begin
      // Another pointer use flips the selection at once.
      wr_en = 1'b1;
      wr_slot = S_SEL;
      wr_data = sel_upd; // RQ3
    end
    // Reads look at the slot of the address on the bus every cycle.
    rd_slot = bus_slot;
  end

  // Holds the rest of a pointer step so it lands in the next cycles.
  // A step that meets a bus write or an unfinished step is not taken,
  // so the sequencer must keep two quiet cycles between steps.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hw_pend_r <= 1'b0;
      hw_hi_r <= RST_VAL;
      hw_sel_r <= 1'b0;
      hw_tog_r <= 1'b0;
    end else begin
      if (ptr_step && !bus_wr_ok && !hw_pend_r && !hw_tog_r) begin
        // Capture the high byte and the pointer that it belongs to.
        hw_pend_r <= 1'b1;
        hw_hi_r <= stepped[15:8];
        hw_sel_r <= sel;
        hw_tog_r <= auto_toggle_enable; // RQ13
      end else if (hw_pend_r && !bus_wr_ok) begin
        // The high byte has taken the port this cycle.
        hw_pend_r <= 1'b0;
      end else if (hw_tog_r && !hw_pend_r && !bus_wr_ok) begin
        // The delayed toggle has taken the port this cycle.
        hw_tog_r <= 1'b0;
      end
    end
  end

  // Register storage with registered read data.
  reg_mem u_mem (
    .pclk(pclk),
    .presetn(presetn),
    .wr_en(wr_en),
    .wr_slot(wr_slot),
    .wr_data(wr_data),
    .rd_slot(rd_slot),
    .rd_data(mem_rd),
    .all_q(q)
  );

  // Unlock sequence: two keys back to back open a short write window.
  // Any other completed write to a mapped register between the keys starts the sequence
  // again, so a stray write cannot leave the window half armed.
  always_comb begin
    ul_nxt = ul_r;
    ul_cnt_nxt = ul_cnt_r;
    unique case (ul_r)
      UL_IDLE: begin
        if (bus_wr && bus_slot == S_UNL && pwdata[7:0] == KEY1) begin
          ul_nxt = UL_KEY1;
        end
      end
      UL_KEY1: begin
        if (bus_wr && bus_slot == S_UNL && pwdata[7:0] == KEY2) begin
          ul_nxt = UL_OPEN;
          ul_cnt_nxt = UNLOCK_CYC;
        end else if (bus_wr) begin
          ul_nxt = UL_IDLE;
        end
      end
      UL_OPEN: begin
        // One relocation write, or the window running out, closes it.
        if ((bus_wr && bus_slot == S_RELOC) || ul_cnt_r == 3'h0) begin
          ul_nxt = UL_IDLE;
        end else begin
          ul_cnt_nxt = ul_cnt_r - 3'h1;
        end
      end
      default: ul_nxt = UL_IDLE;
    endcase
  end

  // Unlock state register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ul_r <= UL_IDLE;
      ul_cnt_r <= 3'h0;
    end else begin
      ul_r <= ul_nxt;
      ul_cnt_r <= ul_cnt_nxt;
    end
  end

  // Read timing: marks the second access cycle of a read, by which
  // the registered memory data belongs to the address on the bus.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_wait_r <= 1'b0;
    end else begin
      rd_wait_r <= bus_acc && !pwrite && !rd_wait_r;
    end
  end

  // Ready rises one cycle after the access starts for a write, two for
  // a read. All answer outputs come from flip-flops, and the !pready
  // term keeps pready a one-cycle pulse while the master still holds
  // psel and penable at the completing edge.
  wire rdy_nxt = bus_acc && !pready && (pwrite || rd_wait_r);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= rdy_nxt;
      pslverr <= rdy_nxt && !bus_mapped;
      prdata <= (rdy_nxt && !pwrite && bus_mapped) ? {24'h000000, mem_rd}
                                                   : 32'h0000_0000;
    end
  end

  // Address forming for both kinds of move.
  // Pointer moves use the selected pointer and its own top byte; the
  // indirect form uses the working register for the low byte.
  wire [7:0] ind_mid = addressing_control[HSRC_BIT] ? alt_high : port2_latch; // RQ8
  wire [XA_W-1:0] ptr_addr = {sel ? p1x : p0x, act_ptr}; // RQ6
  wire [XA_W-1:0] ind_addr = {mxu, ind_mid, work_reg}; // RQ7 RQ8
  wire [XA_W-1:0] base_nxt = XA_W'({reloc, 12'h000}); // RQ9

  // Registered move address, valid one cycle after the request.
  // The address holds its last value between moves, but only the
  // valid pulse says that it belongs to a new move.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      xaddr <= '0;
      xaddr_valid <= 1'b0;
      external_data_ram_base <= '0;
    end else begin
      xaddr <= move_ptr ? ptr_addr : (move_ind ? ind_addr : xaddr); // RQ11
      xaddr_valid <= move_ptr || move_ind;
      external_data_ram_base <= base_nxt; // RQ9
    end
  end
endmodule // xaddr_gen

// ===== inc/xaddr_pkg.sv
// Package for the dual pointer external data address generator.
// Assumes one 100 MHz clock domain and an APB register slave.
package xaddr_pkg;
  // Register indexes; the bus byte address is four times the index.
  localparam logic [11:0] IDX_P0_LOW = 12'h082;
  localparam logic [11:0] IDX_P0_HIGH = 12'h083;
  localparam logic [11:0] IDX_P1_LOW = 12'h084;
  localparam logic [11:0] IDX_P1_HIGH = 12'h085;
  localparam logic [11:0] IDX_SEL_CTRL = 12'h086;
  localparam logic [11:0] IDX_ADDRESSING_CONTROL = 12'h09D;
  localparam logic [11:0] IDX_P0_TOP = 12'h093;
  localparam logic [11:0] IDX_P1_TOP = 12'h095;
  localparam logic [11:0] IDX_PORT2 = 12'h0A0;
  localparam logic [11:0] IDX_ALT_HIGH = 12'h0DA;
  localparam logic [11:0] IDX_RELOC = 12'h0C6;
  localparam logic [11:0] IDX_UNLOCK = 12'h0C7;
  localparam logic [11:0] IDX_IND_UPPER = 12'h0EA;
  // Number of register slots held in the register memory.
  localparam int NREG = 13;
  // Slot numbers inside the register memory.
  localparam logic [3:0] S_P0L = 4'h0;
  localparam logic [3:0] S_P0H = 4'h1;
  localparam logic [3:0] S_P1L = 4'h2;
  localparam logic [3:0] S_P1H = 4'h3;
  localparam logic [3:0] S_SEL = 4'h4;
  localparam logic [3:0] S_ADDRESSING_CONTROL = 4'h5;
  localparam logic [3:0] S_P0X = 4'h6;
  localparam logic [3:0] S_P1X = 4'h7;
  localparam logic [3:0] S_P2 = 4'h8;
  localparam logic [3:0] S_ALT = 4'h9;
  localparam logic [3:0] S_RELOC = 4'hA;
  localparam logic [3:0] S_UNL = 4'hB;
  localparam logic [3:0] S_MXU = 4'hC;
  // Select control field positions.
  localparam int SEL_BIT = 0;
  localparam int TSL_BIT = 5;
  localparam int DIR_LO = 6;
  localparam int DIR_HI = 7;
  // Writable masks.
  localparam logic [7:0] SEL_MASK = 8'hE1;
  localparam logic [7:0] ADDRESSING_CONTROL_MASK = 8'h08;
  localparam int HSRC_BIT = 3;
  // Unlock key pair written in order to the unlock register.
  localparam logic [7:0] KEY1 = 8'hAA;
  localparam logic [7:0] KEY2 = 8'h55;
  // Loaded after the second key; the unlock stays open this many cycles plus one.
  localparam logic [2:0] UNLOCK_CYC = 3'h4;
  // Reset value of all registers.
  localparam logic [7:0] RST_VAL = 8'h00;
  // Relocation step is 4KB, so the base shifts left by this much.
  localparam int RELOC_SHIFT = 12;
  // Address width of the external data path.
  localparam int XA_W = 24;
  // Unlock states.
  typedef enum logic [1:0] {UL_IDLE, UL_KEY1, UL_OPEN} unlock_t;
endpackage

// ===== core/reg_mem.sv
// Small register memory holding the byte registers of the address block.
// Assumes writes from one port; all slots clear on reset.
module reg_mem (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic wr_en,
  input wire logic [3:0] wr_slot,
  input wire logic [7:0] wr_data,
  input wire logic [3:0] rd_slot,
  output logic [7:0] rd_data,
  output logic [8*xaddr_pkg::NREG-1:0] all_q
);
  import xaddr_pkg::*;

  // Each slot is a byte register written when its slot number matches.
  // The register is local to its branch, so every variable has one
  // driving process; the flat view lets the address logic see them all.
  genvar g;
  generate
    for (g = 0; g < NREG; g++) begin : g_slot
      logic [7:0] slot_r;
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          slot_r <= RST_VAL;
        end else if (wr_en && (wr_slot == 4'(g))) begin
          slot_r <= wr_data;
        end
      end
      assign all_q[8*g +: 8] = slot_r;
    end
  endgenerate

  // Read data comes out of a register, one cycle after the slot is given.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_data <= RST_VAL;
    end else begin
      rd_data <= (rd_slot < 4'(NREG)) ? all_q[8*rd_slot +: 8] : RST_VAL;
    end
  end
endmodule // reg_mem

// ===== tb/xaddr_monitor.sv
// Port checker for the pointer and move address generator.
// Assumes it is bound to xaddr_gen and sees only that module's ports.
module xaddr_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic ptr_step,
  input wire logic ptr_use,
  input wire logic move_ptr,
  input wire logic move_ind,
  input wire logic [7:0] work_reg,
  input wire logic [xaddr_pkg::XA_W-1:0] xaddr,
  input wire logic xaddr_valid,
  input wire logic [xaddr_pkg::XA_W-1:0] external_data_ram_base
);
  timeunit 1ns;
  timeprecision 1ns;
  import xaddr_pkg::*;
  // One clock domain, so one default clock and reset serve all checks.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Start of a move request, and the two kinds of bus setup cycle.
  sequence s_move; move_ptr || move_ind; endsequence
  sequence s_rd; psel && !penable && !pwrite; endsequence
  sequence s_wr; psel && !penable && pwrite; endsequence
  property p_rd_lat; s_rd |-> !pready ##1 !pready ##1 !pready ##1 pready;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read answer mistimed");
  property p_wr_lat; s_wr |-> !pready ##1 !pready ##1 pready; endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("write answer mistimed");
  property p_pulse; pready |=> !pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready held too long");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_idle_rd; !pready |-> prdata == 32'h0; endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data leaks");
  property p_valid; s_move |=> xaddr_valid; endproperty
  a_valid: assert property (p_valid) else $error("move gave no address");
  property p_cause; xaddr_valid |-> $past(move_ptr || move_ind); endproperty
  a_cause: assert property (p_cause) else $error("address without move");
  property p_low; move_ind |=> xaddr[7:0] == $past(work_reg); endproperty
  a_low: assert property (p_low) else $error("indirect low byte wrong");
  property p_base;
    external_data_ram_base[11:0] == 12'h000 && external_data_ram_base[23:20] == 4'h0;
  endproperty
  a_base: assert property (p_base) else $error("base not in 4KB steps");
endmodule // xaddr_monitor

// ===== tb/cpu_seq.sv
// Behavioural instruction sequencer that pulses pointer and move requests.
// Assumes the caller enters op just after a rising clock edge.
module cpu_seq (
  input wire logic pclk,
  output logic ptr_step,
  output logic ptr_use,
  output logic move_ptr,
  output logic move_ind,
  output logic [7:0] work_reg
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {ptr_step, ptr_use, move_ptr, move_ind, work_reg} = 12'h000;
  // One-cycle pulse of kind k, then three quiet cycles so the step tail ends.
  task op(input int k, input logic [7:0] w);
    ptr_step <= (k == 0);
    ptr_use <= (k == 1);
    move_ptr <= (k == 2);
    move_ind <= (k == 3);
    work_reg <= w;
    @(posedge pclk);
    {ptr_step, ptr_use, move_ptr, move_ind} <= 4'h0;
    // The register value is gone once sampled, so show its inverse.
    work_reg <= ~w;
    repeat (3) @(posedge pclk);
  endtask
endmodule // cpu_seq

// ===== tb/tb.sv
// Self-checking bench for xaddr_gen with a byte model of its registers.
// Assumes xaddr_monitor and cpu_seq are compiled first.
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  import xaddr_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, se;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, ptr_step, ptr_use, move_ptr, move_ind, xaddr_valid;
  logic [7:0] work_reg, v, m[256];
  logic [XA_W-1:0] xaddr, external_data_ram_base, got;
  int err_total = 0, checks = 0, seed = 84;
  logic [11:0] al[12] = '{IDX_P0_LOW, IDX_P0_HIGH, IDX_P1_LOW, IDX_P1_HIGH,
    IDX_SEL_CTRL, IDX_P0_TOP, IDX_P1_TOP, IDX_RELOC, IDX_IND_UPPER,
    IDX_ADDRESSING_CONTROL, IDX_PORT2, IDX_ALT_HIGH};
  always #5 pclk = ~pclk;
  // Keep the last move address, since it is announced for one cycle only.
  always @(posedge pclk) if (xaddr_valid === 1'b1) got <= xaddr;
  xaddr_gen xaddr_gen_inst(.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ptr_step(ptr_step),
    .ptr_use(ptr_use), .move_ptr(move_ptr), .move_ind(move_ind),
    .work_reg(work_reg), .xaddr(xaddr), .xaddr_valid(xaddr_valid),
    .external_data_ram_base(external_data_ram_base));
  cpu_seq cpu_seq_inst(.pclk(pclk), .ptr_step(ptr_step), .ptr_use(ptr_use),
    .move_ptr(move_ptr), .move_ind(move_ind), .work_reg(work_reg));
  task chk(input logic [31:0] s, input logic [31:0] e);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("unexpected at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  function logic [7:0] rnd();
    logic [31:0] r;
    r = $random(seed);
    return r[7:0];
  endfunction
  // APB transfer; psel stays up so a following transfer can set up at once.
  // The index a goes out as its aligned word address; only the
  // watchdog ends a wait for pready.
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a << 2;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    penable <= 1'b0;
  endtask
  task idle;
    psel <= 1'b0;
    @(posedge pclk);
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    apb(1'b1, a, d);
    m[a[7:0]] = d & (a == IDX_SEL_CTRL ? SEL_MASK :
      a == IDX_ADDRESSING_CONTROL ? ADDRESSING_CONTROL_MASK : 8'hFF);
  endtask
  task rdchk(input logic [11:0] a);
    apb(1'b0, a, 8'h00);
    chk(rd, {24'h0, m[a[7:0]]});
  endtask
  // Model of one pointer step: count in 16 bits, then the optional toggle.
  task mstep;
    logic s;
    logic [15:0] p;
    s = m[8'h86][0];
    p = s ? {m[8'h85], m[8'h84]} : {m[8'h83], m[8'h82]};
    p = m[8'h86][6 + s] ? p - 16'h1 : p + 16'h1;
    if (s) {m[8'h85], m[8'h84]} = p;
    else {m[8'h83], m[8'h82]} = p;
    if (m[8'h86][5]) m[8'h86][0] = !s;
  endtask
  function logic [31:0] exp_ptr();
    return m[8'h86][0] ? {8'h0, m[8'h95], m[8'h85], m[8'h84]}
      : {8'h0, m[8'h93], m[8'h83], m[8'h82]};
  endfunction
  task end_sim;
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    err_total++;
    end_sim;
  end
  initial begin
    logic [1:0] d;
    logic s, t;
    foreach (m[i]) m[i] = 8'h00;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    foreach (al[i]) rdchk(al[i]);
    foreach (al[i]) if (al[i] != IDX_RELOC) begin
      wr(al[i], rnd());
      rdchk(al[i]);
    end
    apb(1'b0, 12'h0F0, 8'h00);
    chk({31'h0, se}, 32'h1);
    chk(rd, 32'h0);
    // A locked relocation write must be dropped.
    // Nonzero, so a dropped write differs from one that lands.
    v = rnd() | 8'h01;
    apb(1'b1, IDX_RELOC, v);
    rdchk(IDX_RELOC);
    apb(1'b1, IDX_UNLOCK, KEY1);
    apb(1'b1, IDX_UNLOCK, KEY2);
    wr(IDX_RELOC, v);
    rdchk(IDX_RELOC);
    chk({8'h0, external_data_ram_base}, {12'h0, v, 12'h000});
    // Every direction code, selection and toggle, at the wrap boundary.
    for (int k = 0; k < 16; k++) begin
      {d, t, s} = k[3:0];
      wr(IDX_SEL_CTRL, {d, t, 4'h0, s});
      v = d[s] ? 8'h00 : 8'hFF;
      foreach (al[i]) if (i < 4) wr(al[i], v);
      wr(IDX_P0_TOP, rnd());
      wr(IDX_P1_TOP, rnd());
      idle;
      cpu_seq_inst.op(0, 8'h00);
      mstep;
      rdchk(IDX_SEL_CTRL);
      idle;
      cpu_seq_inst.op(1, 8'h00);
      if (t) m[8'h86][0] = !m[8'h86][0];
      cpu_seq_inst.op(2, 8'h00);
      chk({8'h0, got}, exp_ptr());
      rdchk(IDX_SEL_CTRL);
      idle;
    end
    // Indirect moves with each middle byte source.
    for (int h = 0; h < 2; h++) begin
      wr(IDX_ADDRESSING_CONTROL, {4'h0, h[0], 3'h0});
      wr(IDX_PORT2, rnd());
      wr(IDX_ALT_HIGH, rnd());
      wr(IDX_IND_UPPER, rnd());
      idle;
      v = rnd();
      cpu_seq_inst.op(3, v);
      chk({8'h0, got}, {8'h0, m[8'hEA], h ? m[8'hDA] : m[8'hA0], v});
    end
    end_sim;
  end
endmodule // tb
bind xaddr_gen xaddr_monitor xaddr_monitor_inst(.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .ptr_step(ptr_step), .ptr_use(ptr_use),
  .move_ptr(move_ptr), .move_ind(move_ind), .work_reg(work_reg),
  .xaddr(xaddr), .xaddr_valid(xaddr_valid), .external_data_ram_base(external_data_ram_base));
